/* design/gcr_global_config.sv */
// Global configuration register bank of a programmable clock fanout buffer.
`timescale 1ns/1ps

// Contract
// [RL1] Bank select maps addresses 0x1 up to NVM
// [RL2] NVM mapping only on variants with NVM
// [RL3] ROM window select beats bank select
// [RL4] Soft reset clears all but listed exceptions
// [RL5] Soft reset: no pin latch, no boot
// [RL6] Hard reset acts like reset pin
// [RL7] Global halt stops outputs with source 0001
// [RL8] Output halt is global OR per-output bit
// [RL9] Halt low bits 7..0 drive outputs 8..1
// [RL10] Halt high bits 1..0 drive outputs 10..9
// [RL11] Ring oscillator off only after autoconfig
// [RL12] Open-drain serial out drives low only
// [RL13] Crystal pin mode decodes three codes; code 3 acts as off
// [RL14] Input clock enables for inputs 3..1
// [RL15] Output enable bits gate each output
// [RL16] Rev A: software enables output per bank
// [RL17] Mux one selects paths of groups A-C
// [RL18] Mux two selects paths of groups D-F
// [RL19] Bus address immune to soft/hard reset
// [RL20] Reserved bits read zero, writes ignored
module gcr_global_config
	import gcr_pkg::*;
#(
	parameter bit HAS_NVM = 1'b1
) (
	input  wire logic                  I_CLOCK,
	input  wire logic                  I_RESET,
	input  wire logic                  I_EXTERNAL_RESET_PIN_N,
	input  wire logic [1:0]            I_IF_PINS,
	input  wire logic [GCR_ADDR_W-1:0] I_ADDR,
	input  wire logic                  I_WRITE,
	input  wire logic                  I_READ,
	input  wire logic [7:0]            I_WDATA,
	output logic      [7:0]            O_RDATA,
	input  wire logic                  I_ROM_WINDOW_SELECT,
	input  wire logic                  I_AUTOCONFIG_DONE,
	input  wire logic [39:0]           I_HALT_SOURCE_SELECT,
	input  wire logic                  I_MISO_DATA,
	input  wire logic                  I_MISO_DRIVE,
	output logic                       O_MISO,
	output logic                       O_MISO_OE,
	output logic                       O_MAP_NVM,
	output logic                       O_SOFT_RESET,
	output logic                       O_HARD_RESET,
	output logic                       O_LATCH_PIN_DEFAULTS,
	output logic                       O_BOOT_START,
	output logic                       O_RING_OSC_POWER_DOWN,
	output logic                       O_CRYSTAL_DRIVER_EN,
	output logic                       O_CRYSTAL_PIN_A_INPUT_EN,
	output logic                       O_CRYSTAL_PIN_B_FLOAT,
	output logic      [2:0]            O_INPUT_CLOCK_EN,
	output logic      [9:0]            O_OUTPUT_EN,
	output logic      [5:0]            O_GROUP_PATH_ONE,
	output logic      [5:0]            O_GROUP_PATH_TWO,
	output logic      [9:0]            O_OUTPUT_HALT,
	output logic      [6:0]            O_TWO_WIRE_DEV_ADDR
);

	// Decodes a two-bit path field; unused codes select neither path.
	function automatic logic [1:0] path_decode(input logic [1:0] code);
		path_decode = {code == GCR_PATH_TWO, code == GCR_PATH_ONE};
	endfunction : path_decode

	logic       pin_meta_q;
	logic       pin_sync_q;
	logic [1:0] if_meta_q;
	logic [1:0] if_sync_q;
	logic       ext_rst_q;
	logic       boot_q;
	logic [7:0] bank_q;
	logic       soft_q;
	logic       hard_q;
	logic [7:0] master1_q;
	logic [7:0] master2_q;
	logic [7:0] in_clk_q;
	logic [7:0] out_lo_q;
	logic [7:0] out_hi_q;
	logic [7:0] mux1_q;
	logic [7:0] mux2_q;
	logic [7:0] halt_lo_q;
	logic [7:0] halt_hi_q;
	logic [6:0] dev_addr_q;
	logic       ext_rst;
	logic       cfg_clear;
	logic       bank_write;
	logic [7:0] rdata_d;
	logic [9:0] halt_bits;
	logic [11:0] paths;

	// Reset pin and interface pins are synchronised separately; only the second stage is read.
	always_ff @(posedge I_CLOCK) begin
		if (I_RESET) begin
			pin_meta_q <= 1'b0;
			pin_sync_q <= 1'b0;
		end else begin
			pin_meta_q <= I_EXTERNAL_RESET_PIN_N;
			pin_sync_q <= pin_meta_q;
		end
	end

	always_ff @(posedge I_CLOCK) begin
		if (I_RESET) begin
			if_meta_q <= 2'h0;
			if_sync_q <= 2'h0;
		end else begin
			if_meta_q <= I_IF_PINS;
			if_sync_q <= if_meta_q;
		end
	end

	assign ext_rst = I_RESET | ~pin_sync_q;
	// Hard reset bit clears what the reset pin clears except itself and the device address; soft reset spares the reset bits.
	assign cfg_clear = ext_rst | hard_q | soft_q; // [RL4] [RL6]
	// While the upper space is handed to NVM the bank ignores accesses above offset 0.
	assign O_MAP_NVM  = HAS_NVM & bank_q[GCR_BIT_BANK_SEL] & ~I_ROM_WINDOW_SELECT; // [RL1] [RL2] [RL3]
	assign bank_write = I_WRITE & ~(O_MAP_NVM & (I_ADDR >= GCR_NVM_BASE));

	// Pin defaults are latched and boot is started only when a pin or hard reset ends.
	always_ff @(posedge I_CLOCK) begin
		if (I_RESET) begin
			ext_rst_q <= 1'b1;
			boot_q    <= 1'b0;
		end else begin
			ext_rst_q <= ext_rst | hard_q;
			boot_q    <= ext_rst_q & ~(ext_rst | hard_q); // [RL5] [RL6]
		end
	end
	assign O_LATCH_PIN_DEFAULTS = boot_q;
	assign O_BOOT_START         = boot_q;

	always_ff @(posedge I_CLOCK) begin
		if (ext_rst) begin
			hard_q <= 1'b0;
		end else if (bank_write && I_ADDR == GCR_OFF_MASTER_ONE) begin
			hard_q <= I_WDATA[GCR_BIT_HARD_RST]; // [RL6]
		end
	end

	always_ff @(posedge I_CLOCK) begin
		if (ext_rst || hard_q) begin
			soft_q <= 1'b0;
		end else if (bank_write && I_ADDR == GCR_OFF_MASTER_ONE) begin
			soft_q <= I_WDATA[GCR_BIT_SOFT_RST]; // [RL4]
		end
	end

	// Each register has its own block; cfg_clear covers pin, hard and soft reset alike.
	always_ff @(posedge I_CLOCK) begin
		if (cfg_clear) begin
			bank_q <= GCR_RST_REG;
		end else if (bank_write && I_ADDR == GCR_OFF_BANK_SEL) begin
			bank_q <= I_WDATA & GCR_MASK_BANK_SEL; // [RL20]
		end
	end

	always_ff @(posedge I_CLOCK) begin
		if (cfg_clear) begin
			master1_q <= GCR_RST_REG;
		end else if (bank_write && I_ADDR == GCR_OFF_MASTER_ONE) begin
			master1_q <= I_WDATA & GCR_MASK_MASTER1 & 8'h2f;
			// The ring oscillator clocks autoconfig, so it may only stop afterwards.
			master1_q[GCR_BIT_RING_OFF] <= I_WDATA[GCR_BIT_RING_OFF] & I_AUTOCONFIG_DONE; // [RL11]
		end
	end

	always_ff @(posedge I_CLOCK) begin
		if (cfg_clear) begin
			master2_q <= GCR_RST_REG;
		end else if (bank_write && I_ADDR == GCR_OFF_MASTER_TWO) begin
			master2_q <= I_WDATA & GCR_MASK_MASTER2;
		end
	end

	always_ff @(posedge I_CLOCK) begin
		if (cfg_clear) begin
			in_clk_q <= GCR_RST_REG;
		end else if (bank_write && I_ADDR == GCR_OFF_IN_CLK_EN) begin
			in_clk_q <= I_WDATA & GCR_MASK_IN_CLK;
		end
	end

	always_ff @(posedge I_CLOCK) begin
		if (cfg_clear) begin
			out_lo_q <= GCR_RST_REG;
		end else if (bank_write && I_ADDR == GCR_OFF_OUT_EN_LO) begin
			out_lo_q <= I_WDATA & GCR_MASK_OUT_LO;
		end
	end

	always_ff @(posedge I_CLOCK) begin
		if (cfg_clear) begin
			out_hi_q <= GCR_RST_REG;
		end else if (bank_write && I_ADDR == GCR_OFF_OUT_EN_HI) begin
			out_hi_q <= I_WDATA & GCR_MASK_OUT_HI;
		end
	end

	always_ff @(posedge I_CLOCK) begin
		if (cfg_clear) begin
			mux1_q <= GCR_RST_REG;
		end else if (bank_write && I_ADDR == GCR_OFF_MUX_ONE) begin
			mux1_q <= I_WDATA & GCR_MASK_MUX;
		end
	end

	always_ff @(posedge I_CLOCK) begin
		if (cfg_clear) begin
			mux2_q <= GCR_RST_REG;
		end else if (bank_write && I_ADDR == GCR_OFF_MUX_TWO) begin
			mux2_q <= I_WDATA & GCR_MASK_MUX;
		end
	end

	always_ff @(posedge I_CLOCK) begin
		if (cfg_clear) begin
			halt_lo_q <= GCR_RST_REG;
		end else if (bank_write && I_ADDR == GCR_OFF_HALT_LO) begin
			halt_lo_q <= I_WDATA & GCR_MASK_OUT_LO;
		end
	end

	always_ff @(posedge I_CLOCK) begin
		if (cfg_clear) begin
			halt_hi_q <= GCR_RST_REG;
		end else if (bank_write && I_ADDR == GCR_OFF_HALT_HI) begin
			halt_hi_q <= I_WDATA & GCR_MASK_OUT_HI;
		end
	end

	// Only the pin reset reloads the device address; soft and hard reset bits leave it alone.
	always_ff @(posedge I_CLOCK) begin
		if (I_RESET) begin
			dev_addr_q <= GCR_RST_DEV_ADDR;
		end else if (~pin_sync_q) begin
			dev_addr_q <= {GCR_RST_DEV_ADDR[6:2], if_sync_q}; // [RL19]
		end else if (bank_write && I_ADDR == GCR_OFF_DEV_ADDR) begin
			dev_addr_q <= I_WDATA[6:0] & GCR_MASK_DEV_ADDR[6:0];
		end
	end

	always_comb begin
		rdata_d = 8'h00; // [RL20]
		if (!(O_MAP_NVM && I_ADDR >= GCR_NVM_BASE)) begin
			case (I_ADDR)
				GCR_OFF_BANK_SEL:   rdata_d = bank_q;
				GCR_OFF_MASTER_ONE: rdata_d = master1_q | {soft_q, hard_q, 6'h00};
				GCR_OFF_MASTER_TWO: rdata_d = master2_q;
				GCR_OFF_IN_CLK_EN:  rdata_d = in_clk_q;
				GCR_OFF_OUT_EN_LO:  rdata_d = out_lo_q;
				GCR_OFF_OUT_EN_HI:  rdata_d = out_hi_q;
				GCR_OFF_MUX_ONE:    rdata_d = mux1_q;
				GCR_OFF_MUX_TWO:    rdata_d = mux2_q;
				GCR_OFF_HALT_LO:    rdata_d = halt_lo_q;
				GCR_OFF_HALT_HI:    rdata_d = halt_hi_q;
				GCR_OFF_DEV_ADDR:   rdata_d = {1'b0, dev_addr_q};
				default:            rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge I_CLOCK) begin
		if (I_RESET) begin
			O_RDATA <= 8'h00;
		end else if (I_READ) begin
			O_RDATA <= rdata_d;
		end
	end

	assign O_SOFT_RESET          = soft_q;
	assign O_HARD_RESET          = hard_q;
	assign O_TWO_WIRE_DEV_ADDR   = dev_addr_q;
	assign O_RING_OSC_POWER_DOWN = master1_q[GCR_BIT_RING_OFF]; // [RL11]

	// Open-drain mode never drives a one, so the line relies on its pull-up.
	always_comb begin
		if (master1_q[GCR_BIT_OPEN_DRAIN]) begin
			O_MISO    = 1'b0; // [RL12]
			O_MISO_OE = I_MISO_DRIVE & ~I_MISO_DATA;
		end else begin
			O_MISO    = I_MISO_DATA;
			O_MISO_OE = I_MISO_DRIVE;
		end
	end

	assign O_CRYSTAL_DRIVER_EN      = master2_q[1:0] == GCR_XTAL_DRIVER; // [RL13]
	assign O_CRYSTAL_PIN_A_INPUT_EN = master2_q[1:0] == GCR_XTAL_DRIVER || master2_q[1:0] == GCR_XTAL_SINGLE;
	assign O_CRYSTAL_PIN_B_FLOAT    = master2_q[1:0] != GCR_XTAL_DRIVER;
	assign O_INPUT_CLOCK_EN         = in_clk_q[2:0]; // [RL14]
	assign O_OUTPUT_EN              = {out_hi_q[1:0], out_lo_q}; // [RL15]
	assign halt_bits                = {halt_hi_q[1:0], halt_lo_q}; // [RL9] [RL10]
	assign paths                    = {mux2_q[5:0], mux1_q[5:0]};

	for (genvar g = 0; g < 6; g++) begin : g_group
		logic [1:0] sel;
		assign sel                 = path_decode(paths[2*g +: 2]); // [RL17] [RL18]
		assign O_GROUP_PATH_ONE[g] = sel[0];
		assign O_GROUP_PATH_TWO[g] = sel[1];
	end

	for (genvar o = 0; o < 10; o++) begin : g_halt
		assign O_OUTPUT_HALT[o] = (I_HALT_SOURCE_SELECT[4*o +: 4] == GCR_HALT_SRC_REG)
			& (master1_q[GCR_BIT_GLOBAL_HLT] | halt_bits[o]); // [RL7] [RL8]
	end

endmodule : gcr_global_config

/* design/gcr_pkg.sv */
// Package with offsets, field positions, masks and reset values of the global configuration registers.
package gcr_pkg;
	localparam int          GCR_ADDR_W         = 12;
	localparam logic [11:0] GCR_OFF_BANK_SEL   = 12'h000;
	localparam logic [11:0] GCR_OFF_MASTER_ONE = 12'h001;
	localparam logic [11:0] GCR_OFF_MASTER_TWO = 12'h002;
	localparam logic [11:0] GCR_OFF_IN_CLK_EN  = 12'h004;
	localparam logic [11:0] GCR_OFF_OUT_EN_LO  = 12'h005;
	localparam logic [11:0] GCR_OFF_OUT_EN_HI  = 12'h006;
	localparam logic [11:0] GCR_OFF_MUX_ONE    = 12'h007;
	localparam logic [11:0] GCR_OFF_MUX_TWO    = 12'h008;
	localparam logic [11:0] GCR_OFF_HALT_LO    = 12'h009;
	localparam logic [11:0] GCR_OFF_HALT_HI    = 12'h00a;
	localparam logic [11:0] GCR_OFF_DEV_ADDR   = 12'h011;
	localparam logic [11:0] GCR_NVM_BASE       = 12'h001;
	localparam int          GCR_BIT_BANK_SEL   = 7;
	localparam int          GCR_BIT_SOFT_RST   = 7;
	localparam int          GCR_BIT_HARD_RST   = 6;
	localparam int          GCR_BIT_GLOBAL_HLT = 5;
	localparam int          GCR_BIT_RING_OFF   = 3;
	localparam int          GCR_BIT_OPEN_DRAIN = 1;
	localparam logic [7:0]  GCR_MASK_BANK_SEL  = 8'h80;
	localparam logic [7:0]  GCR_MASK_MASTER1   = 8'hea;
	localparam logic [7:0]  GCR_MASK_MASTER2   = 8'h03;
	localparam logic [7:0]  GCR_MASK_IN_CLK    = 8'h07;
	localparam logic [7:0]  GCR_MASK_OUT_LO    = 8'hff;
	localparam logic [7:0]  GCR_MASK_OUT_HI    = 8'h03;
	localparam logic [7:0]  GCR_MASK_MUX       = 8'h3f;
	localparam logic [7:0]  GCR_MASK_DEV_ADDR  = 8'h7f;
	localparam logic [7:0]  GCR_RST_REG        = 8'h00;
	localparam logic [6:0]  GCR_RST_DEV_ADDR   = 7'h74;
	localparam logic [1:0]  GCR_XTAL_OFF       = 2'h0;
	localparam logic [1:0]  GCR_XTAL_DRIVER    = 2'h1;
	localparam logic [1:0]  GCR_XTAL_SINGLE    = 2'h2;
	localparam logic [1:0]  GCR_PATH_ONE       = 2'h1;
	localparam logic [1:0]  GCR_PATH_TWO       = 2'h3;
	localparam logic [3:0]  GCR_HALT_SRC_REG   = 4'h1;
endpackage : gcr_pkg

/* sim/gcr_props.sv */
// Concurrent checks on the ports of the global configuration register bank.
`timescale 1ns/1ps
module gcr_props
	import gcr_pkg::*;
(
	input wire logic                  I_CLOCK,
	input wire logic                  I_RESET,
	input wire logic                  I_WRITE,
	input wire logic                  I_READ,
	input wire logic                  I_AUTOCONFIG_DONE,
	input wire logic                  I_MISO_DATA,
	input wire logic [GCR_ADDR_W-1:0] I_ADDR,
	input wire logic [7:0]            I_WDATA,
	input wire logic [7:0]            O_RDATA,
	input wire logic [39:0]           I_HALT_SOURCE_SELECT,
	input wire logic                  O_MISO,
	input wire logic                  O_MISO_OE,
	input wire logic                  O_MAP_NVM,
	input wire logic                  O_SOFT_RESET,
	input wire logic                  O_HARD_RESET,
	input wire logic                  O_BOOT_START,
	input wire logic                  O_LATCH_PIN_DEFAULTS,
	input wire logic                  O_RING_OSC_POWER_DOWN,
	input wire logic                  O_CRYSTAL_DRIVER_EN,
	input wire logic                  O_CRYSTAL_PIN_A_INPUT_EN,
	input wire logic                  O_CRYSTAL_PIN_B_FLOAT,
	input wire logic [2:0]            O_INPUT_CLOCK_EN,
	input wire logic [9:0]            O_OUTPUT_EN,
	input wire logic [9:0]            O_OUTPUT_HALT
);
	default clocking @(posedge I_CLOCK); endclocking
	default disable iff (I_RESET);
	a_miso_level: assert property (O_MISO_OE |-> O_MISO == I_MISO_DATA)
		else $error("serial out level wrong");
	a_xtal_decode: assert property (O_CRYSTAL_DRIVER_EN |-> O_CRYSTAL_PIN_A_INPUT_EN && !O_CRYSTAL_PIN_B_FLOAT)
		else $error("crystal decode wrong");
	a_outen_write: assert property (I_WRITE && I_ADDR == GCR_OFF_OUT_EN_LO && !O_MAP_NVM && !O_SOFT_RESET
		&& !O_HARD_RESET |=> O_OUTPUT_EN[7:0] == $past(I_WDATA)) else $error("output enable not written");
	a_halt_source: assert property (I_HALT_SOURCE_SELECT[3:0] != GCR_HALT_SRC_REG |-> !O_OUTPUT_HALT[0])
		else $error("halt without register source");
	a_reserved_read: assert property (I_READ && I_ADDR == GCR_OFF_OUT_EN_HI |=> O_RDATA[7:2] == 6'h00)
		else $error("reserved bits not zero");
	a_nvm_read: assert property (I_READ && O_MAP_NVM && I_ADDR >= GCR_NVM_BASE |=> O_RDATA == 8'h00)
		else $error("register seen while bank mapped");
	a_soft_clear: assert property (O_SOFT_RESET |=> O_OUTPUT_EN == 10'h000 && O_INPUT_CLOCK_EN == 3'h0)
		else $error("soft reset left config set");
	a_boot_pulse: assert property (O_BOOT_START |-> O_LATCH_PIN_DEFAULTS ##1 !O_BOOT_START)
		else $error("boot pulse malformed");
	a_ring_gate: assert property ($rose(O_RING_OSC_POWER_DOWN) |-> $past(I_AUTOCONFIG_DONE))
		else $error("ring off before autoconfig");
	c_boot: cover property (O_BOOT_START);
	c_nvm: cover property (O_MAP_NVM);
	c_halt: cover property (O_OUTPUT_HALT == 10'h3ff);
endmodule : gcr_props
bind gcr_global_config gcr_props gcr_props_i (
	.I_CLOCK(I_CLOCK),
	.I_RESET(I_RESET),
	.I_WRITE(I_WRITE),
	.I_READ(I_READ),
	.I_AUTOCONFIG_DONE(I_AUTOCONFIG_DONE),
	.I_MISO_DATA(I_MISO_DATA),
	.I_ADDR(I_ADDR),
	.I_WDATA(I_WDATA),
	.O_RDATA(O_RDATA),
	.I_HALT_SOURCE_SELECT(I_HALT_SOURCE_SELECT),
	.O_MISO(O_MISO),
	.O_MISO_OE(O_MISO_OE),
	.O_MAP_NVM(O_MAP_NVM),
	.O_SOFT_RESET(O_SOFT_RESET),
	.O_HARD_RESET(O_HARD_RESET),
	.O_BOOT_START(O_BOOT_START),
	.O_LATCH_PIN_DEFAULTS(O_LATCH_PIN_DEFAULTS),
	.O_RING_OSC_POWER_DOWN(O_RING_OSC_POWER_DOWN),
	.O_CRYSTAL_DRIVER_EN(O_CRYSTAL_DRIVER_EN),
	.O_CRYSTAL_PIN_A_INPUT_EN(O_CRYSTAL_PIN_A_INPUT_EN),
	.O_CRYSTAL_PIN_B_FLOAT(O_CRYSTAL_PIN_B_FLOAT),
	.O_INPUT_CLOCK_EN(O_INPUT_CLOCK_EN),
	.O_OUTPUT_EN(O_OUTPUT_EN),
	.O_OUTPUT_HALT(O_OUTPUT_HALT)
);

/* sim/gcr_host_model.sv */
// Host model that reaches the register bank through its strobe port.
`timescale 1ns/1ps
module gcr_host_model
	import gcr_pkg::*;
(
	input  wire logic                  i_clock,
	input  wire logic [7:0]            i_rdata,
	output logic      [GCR_ADDR_W-1:0] o_addr = '0,
	output logic                       o_write = 1'b0,
	output logic                       o_read = 1'b0,
	output logic      [7:0]            o_wdata = 8'h00
);
	// Idle address and data are inverted so a stale value never looks valid.
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(negedge i_clock);
		o_addr = a;
		o_wdata = d;
		o_write = 1'b1;
		@(negedge i_clock);
		o_write = 1'b0;
		o_addr = ~a;
		o_wdata = ~d;
	endtask : wr
	task automatic rd(input logic [11:0] a, output logic [7:0] d);
		@(negedge i_clock);
		o_addr = a;
		o_read = 1'b1;
		@(negedge i_clock);
		o_read = 1'b0;
		o_addr = ~a;
		d = i_rdata;
	endtask : rd
endmodule : gcr_host_model

/* sim/test_gcr_global_config.sv */
// Self-checking bench for the global configuration register bank.
`timescale 1ns/1ps
module test_gcr_global_config;
	import gcr_pkg::*;
	logic clk = 1'b0, rst = 1'b1, pin_n = 1'b1, rom = 1'b0, acd = 1'b0, mdat = 1'b0, mdrv = 1'b0;
	logic [1:0] ifp = 2'h0;
	logic [39:0] src = {10{4'h1}};
	logic [11:0] adr;
	logic ws, rs, miso, oe, nvm, soft_reset_bit, hard_reset_bit, lat, boot, ring, xd, xa, xb;
	logic [7:0] wd, rdat, d;
	logic [2:0] input_clock_enable;
	logic [9:0] oen, halt;
	logic [5:0] p1, p2;
	logic [6:0] dev;
	logic [7:0] msk [11] = '{8'h00, 8'h00, 8'h03, 8'h00, 8'h07, 8'hff, 8'h03, 8'h3f, 8'h3f, 8'hff, 8'h03};
	int fails = 0, checked = 0, cyc = 0, k;
	always #5 clk = ~clk;
	gcr_host_model h_i (.i_clock(clk), .i_rdata(rdat), .o_addr(adr), .o_write(ws), .o_read(rs), .o_wdata(wd));
	gcr_global_config gcr_global_config_i (.I_CLOCK(clk), .I_RESET(rst), .I_EXTERNAL_RESET_PIN_N(pin_n),
		.I_IF_PINS(ifp), .I_ADDR(adr), .I_WRITE(ws), .I_READ(rs), .I_WDATA(wd), .O_RDATA(rdat),
		.I_ROM_WINDOW_SELECT(rom), .I_AUTOCONFIG_DONE(acd), .I_HALT_SOURCE_SELECT(src), .I_MISO_DATA(mdat),
		.I_MISO_DRIVE(mdrv), .O_MISO(miso), .O_MISO_OE(oe), .O_MAP_NVM(nvm), .O_SOFT_RESET(soft_reset_bit),
		.O_HARD_RESET(hard_reset_bit), .O_LATCH_PIN_DEFAULTS(lat), .O_BOOT_START(boot), .O_RING_OSC_POWER_DOWN(ring),
		.O_CRYSTAL_DRIVER_EN(xd), .O_CRYSTAL_PIN_A_INPUT_EN(xa), .O_CRYSTAL_PIN_B_FLOAT(xb),
		.O_INPUT_CLOCK_EN(input_clock_enable), .O_OUTPUT_EN(oen), .O_GROUP_PATH_ONE(p1), .O_GROUP_PATH_TWO(p2),
		.O_OUTPUT_HALT(halt), .O_TWO_WIRE_DEV_ADDR(dev));
	task automatic chk(input string n, input logic [9:0] e, input logic [9:0] g);
		checked++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic rchk(input logic [11:0] a, input logic [7:0] e);
		h_i.rd(a, d);
		chk("read data", {2'h0, e}, {2'h0, d});
	endtask : rchk
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : give_verdict
	// Whole run is well under a thousand cycles.
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			fails++;
			give_verdict();
		end
	end
	initial begin
		repeat (6) @(negedge clk);
		rst = 1'b0;
		repeat (4) @(negedge clk);
		for (int a = 0; a < 11; a++) rchk(12'(a), 8'h00);
		chk("device address", 10'h074, {3'h0, dev});
		$display("reset values done");
		for (int a = 2; a < 11; a++) begin
			h_i.wr(12'(a), 8'hff);
			rchk(12'(a), msk[a]);
		end
		rchk(12'h0ff, 8'h00);
		chk("input enables", 10'h007, {7'h0, input_clock_enable});
		chk("output enables", 10'h3ff, oen);
		chk("paths", 10'h03f, {4'h0, p2 & ~p1});
		chk("halt all", 10'h3ff, halt);
		src[31:28] = 4'h2;
		#1 chk("halt source", 10'h37f, halt);
		src = {10{4'h1}};
		h_i.wr(GCR_OFF_HALT_LO, 8'h80);
		h_i.wr(GCR_OFF_HALT_HI, 8'h02);
		chk("halt map", 10'h280, halt);
		h_i.wr(GCR_OFF_MASTER_ONE, 8'h20);
		chk("global halt", 10'h3ff, halt);
		src[3:0] = 4'h0;
		#1 chk("global source", 10'h3fe, halt);
		src = {10{4'h1}};
		$display("enables and halts done");
		for (int c = 0; c < 4; c++) begin
			h_i.wr(GCR_OFF_MUX_ONE, {2'h0, 2'(c), 2'(c), 2'(c)});
			h_i.wr(GCR_OFF_MUX_TWO, {2'h0, 2'(c), 2'(c), 2'(c)});
			chk("path one", {4'h0, {6{c == 1}}}, {4'h0, p1});
			chk("path two", {4'h0, {6{c == 3}}}, {4'h0, p2});
			h_i.wr(GCR_OFF_MASTER_TWO, 8'(c));
			chk("crystal", (c == 1) ? 10'h6 : (c == 2) ? 10'h3 : 10'h1, {7'h0, xd, xa, xb});
		end
		for (int i = 0; i < 4; i++) begin
			h_i.wr(GCR_OFF_MASTER_ONE, {6'h0, i[1], 1'b0});
			mdrv = 1'b1;
			mdat = i[0];
			#1 chk("drive", {9'h0, !(i[1] && i[0])}, {9'h0, oe});
			if (!(i[1] && i[0])) chk("level", {9'h0, i[0]}, {9'h0, miso});
		end
		mdrv = 1'b0;
		#1 chk("released", 10'h0, {9'h0, oe});
		h_i.wr(GCR_OFF_MASTER_ONE, 8'h08);
		chk("ring early", 10'h0, {9'h0, ring});
		acd = 1'b1;
		h_i.wr(GCR_OFF_MASTER_ONE, 8'h08);
		chk("ring off", 10'h1, {9'h0, ring});
		$display("modes done");
		h_i.wr(GCR_OFF_BANK_SEL, 8'h80);
		chk("bank", 10'h1, {9'h0, nvm});
		h_i.wr(GCR_OFF_OUT_EN_LO, 8'h00);
		rchk(GCR_OFF_OUT_EN_LO, 8'h00);
		rom = 1'b1;
		#1 chk("rom window", 10'h0, {9'h0, nvm});
		rom = 1'b0;
		h_i.wr(GCR_OFF_BANK_SEL, 8'h00);
		rchk(GCR_OFF_OUT_EN_LO, 8'hff);
		$display("bank select done");
		h_i.wr(GCR_OFF_DEV_ADDR, 8'h22);
		h_i.wr(GCR_OFF_MASTER_ONE, 8'h80);
		@(negedge clk);
		chk("soft", 10'h1, {9'h0, soft_reset_bit & ~oen[0]});
		h_i.wr(GCR_OFF_OUT_EN_LO, 8'h11);
		h_i.wr(GCR_OFF_MASTER_ONE, 8'h00);
		k = 0;
		repeat (3) @(negedge clk) k += int'(boot === 1'b1);
		chk("soft boot", 10'h0, 10'(k));
		rchk(GCR_OFF_OUT_EN_LO, 8'h00);
		h_i.wr(GCR_OFF_IN_CLK_EN, 8'h07);
		h_i.wr(GCR_OFF_MASTER_ONE, 8'h40);
		@(negedge clk);
		chk("hard", 10'h1, {9'h0, hard_reset_bit && input_clock_enable == 3'h0});
		k = 0;
		h_i.wr(GCR_OFF_MASTER_ONE, 8'h00);
		repeat (5) @(negedge clk) k += int'(boot === 1'b1 && lat === 1'b1);
		chk("boot pulses", 10'h1, 10'(k));
		chk("kept address", 10'h022, {3'h0, dev});
		ifp = 2'h3;
		pin_n = 1'b0;
		repeat (4) @(negedge clk);
		pin_n = 1'b1;
		repeat (4) @(negedge clk);
		chk("pin address", 10'h077, {3'h0, dev});
		$display("resets done");
		give_verdict();
	end
endmodule : test_gcr_global_config
